// File: design/aho_port.sv
// Adapter host I/O port: instruction decode, latches, timers, telemetry
//
// Function
// - Telemetry word load stores fifteen processor bits into a sixteen-bit word.
// - Sixteenth telemetry bit is odd parity over the fifteen data bits.
// - Series-first flag bit is stored alongside the telemetry word.
// - On equipment request send forty bits serially.
// - Word-done strobe raises the telemetry-complete interrupt latch.
// - Strobe with timer two above wired constant blocks strobe interrupts, flags failure.
// - Each interrupt condition sets its own latch, held until processor clears it.
// - Interrupt asserts only outside routines, uninhibited, and without multiply or divide.
// - Interrupt latches are readable as a discrete input word.
// - Discrete outputs are written as words of up to 26 bits.
// - Set and reset of output latches use distinct addresses.
// - Interrupt latches are cleared through a discrete output address.
// - Discrete inputs are read as addressed words of up to 26 bits.
// - First address bit selects direction, one meaning adapter to processor.
// - Third address bit selects delay lines or discretes, forming four groups.
// - Fourth bit picks set gates when one, reset gates when zero.
// - Fifth bit picks memory output when one, accumulator when zero.
// - Bits six to eight pick one of three output subgroups, one-hot.
// - Second address bit sets or clears the interrupt inhibit.
// - Bits four to eight pick one of five input subgroups, one-hot.
// - Fourth bit selects delay line one when set, line two otherwise.
// - Timers load negative, count toward zero per loop, interrupt at zero.
`timescale 1ns/1ps
`default_nettype none
`include "aho_defines.svh"
module aho_port #(
  parameter int unsigned LOOP_CYCLES = (`AHO_LOOP_NS * `AHO_CLK_MHZ) / 1000,
  parameter logic [`AHO_DL_W-1:0] RATE_LIMIT = `AHO_RATE_LIMIT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Processor side
  input wire logic [`AHO_WORD_W-1:0] mem_word_i,
  input wire logic in_routine_i,
  input wire logic muldiv_busy_i,
  output logic host_irq_o,
  // Discrete lines
  input wire logic [3*`AHO_WORD_W-1:0] disc_in_i,
  output logic [2*`AHO_WORD_W-1:0] disc_out_o,
  // Telemetry equipment
  input wire logic tlm_req_i,
  input wire logic tlm_shift_i,
  input wire logic tlm_end_i,
  output logic tlm_data_o,
  output logic tlm_busy_o
);
  localparam int SW = 3 * `AHO_WORD_W + 3;

  // Pin synchronisers
  logic [SW-1:0] sync1;
  logic [SW-1:0] sync2;
  logic [2:0] strobe_d;
  logic req_s, shift_s, end_s;
  logic req_p, shift_p, end_p;
  logic [3*`AHO_WORD_W-1:0] din_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      strobe_d <= 3'h0;
    end else begin
      sync1 <= {tlm_end_i, tlm_shift_i, tlm_req_i, disc_in_i};
      sync2 <= sync1;
      strobe_d <= {end_s, shift_s, req_s};
    end
  end

  assign din_s = sync2[3*`AHO_WORD_W-1:0];
  assign req_s = sync2[SW-3];
  assign shift_s = sync2[SW-2];
  assign end_s = sync2[SW-1];
  assign req_p = req_s & ~strobe_d[0];
  assign shift_p = shift_s & ~strobe_d[1];
  assign end_p = end_s & ~strobe_d[2];

  // Bus handshake: one cycle to decode, ack on the next
  logic pend;
  logic bus_req;
  logic fire;
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign fire = pend;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend <= 1'b0;
      wb_ack_o <= 1'b0;
    end else begin
      pend <= bus_req & ~pend & ~wb_ack_o;
      wb_ack_o <= pend;
    end
  end

  // Instruction address decode
  logic [`AHO_PIO_W-1:0] processor_io_instruction;
  aho_pkg::aho_group_t grp;
  logic dir_in;
  logic wr_ok, rd_ok;
  logic [2:0] dout_sub;
  logic [4:0] din_sub;
  logic [3:0] dl_slot;
  logic [`AHO_WORD_W-1:0] src;
  logic dout_wr, dl_wr, tlm_wr;

  assign processor_io_instruction = wb_adr_i[`AHO_PIO_LSB +: `AHO_PIO_W];
  assign dir_in = processor_io_instruction[`AHO_A1];
  assign grp = aho_pkg::aho_group_t'({processor_io_instruction[`AHO_A3], processor_io_instruction[`AHO_A1]});
  assign wr_ok = fire & wb_we_i & ~dir_in;
  assign rd_ok = fire & ~wb_we_i & dir_in;
  assign dout_sub = {processor_io_instruction[`AHO_A8], processor_io_instruction[`AHO_A7], processor_io_instruction[`AHO_A6]};
  assign din_sub = {processor_io_instruction[`AHO_A8], processor_io_instruction[`AHO_A7], processor_io_instruction[`AHO_A6], processor_io_instruction[`AHO_A5], processor_io_instruction[`AHO_A4]};
  assign dl_slot = {~processor_io_instruction[`AHO_A4], processor_io_instruction[`AHO_A6], processor_io_instruction[`AHO_A7], processor_io_instruction[`AHO_A8]};
  assign src = processor_io_instruction[`AHO_A5] ? mem_word_i : wb_dat_i[`AHO_WORD_W-1:0];
  assign dout_wr = wr_ok & (grp == aho_pkg::AHO_GRP_DOUT);
  assign dl_wr = wr_ok & (grp == aho_pkg::AHO_GRP_DLLOAD);
  assign tlm_wr = dl_wr & (dl_slot == `AHO_SLOT_TLM);

  function automatic logic [`AHO_WORD_W-1:0] gate_word(input logic [`AHO_WORD_W-1:0] cur,
      input logic [`AHO_WORD_W-1:0] val, input logic set);
    return set ? (cur | val) : (cur & ~val);
  endfunction

  // Discrete output latches
  logic [`AHO_WORD_W-1:0] dout0, dout1;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dout0 <= '0;
      dout1 <= '0;
    end else if (dout_wr) begin
      if (dout_sub == 3'h1) begin
        dout0 <= gate_word(dout0, src, processor_io_instruction[`AHO_A4]);
      end
      if (dout_sub == 3'h2) begin
        dout1 <= gate_word(dout1, src, processor_io_instruction[`AHO_A4]);
      end
    end
  end
  assign disc_out_o = {dout1, dout0};

  // Interrupt inhibit
  logic inhibit;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inhibit <= 1'b0;
    end else if (fire) begin
      inhibit <= processor_io_instruction[`AHO_A2];
    end
  end

  // Timed-interrupt counters
  logic [31:0] loop_cnt;
  logic tick;
  logic [`AHO_DL_W-1:0] tmr [2];
  logic [1:0] tmr_run;
  logic [1:0] tmr_zero;
  logic [1:0] tmr_load;
  logic [`AHO_DL_W-1:0] tmr2_left;

  assign tick = (loop_cnt == LOOP_CYCLES - 32'h1);
  assign tmr_load[0] = dl_wr & (dl_slot == `AHO_SLOT_TMR1);
  assign tmr_load[1] = dl_wr & (dl_slot == `AHO_SLOT_TMR2);
  assign tmr2_left = tmr_run[1] ? (~tmr[1] + 13'h0001) : 13'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_cnt <= 32'h0;
    end else begin
      loop_cnt <= tick ? 32'h0 : loop_cnt + 32'h1;
    end
  end

  for (genvar t = 0; t < 2; t++) begin : g_tmr
    assign tmr_zero[t] = tick & tmr_run[t] & (tmr[t] == {`AHO_DL_W{1'b1}}) & ~tmr_load[t];
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tmr[t] <= '0;
        tmr_run[t] <= 1'b0;
      end else if (tmr_load[t]) begin
        tmr[t] <= src[`AHO_DL_W-1:0];
        tmr_run[t] <= |src[`AHO_DL_W-1:0];
      end else if (tick & tmr_run[t]) begin
        tmr[t] <= tmr[t] + 13'h0001;
        tmr_run[t] <= ~tmr_zero[t];
      end
    end
  end

  // Interrupt latches; a new event wins over a clear in the same cycle
  logic [`AHO_IRQ_W-1:0] irq_lat;
  logic [`AHO_IRQ_W-1:0] irq_set;
  logic [`AHO_IRQ_W-1:0] irq_clr;
  logic rate_bad;

  assign rate_bad = end_p & (tmr2_left > RATE_LIMIT);
  assign irq_set[`AHO_IRQ_DONE] = end_p & ~rate_bad & ~irq_lat[`AHO_IRQ_FAIL];
  assign irq_set[`AHO_IRQ_TMR1] = tmr_zero[0];
  assign irq_set[`AHO_IRQ_TMR2] = tmr_zero[1];
  assign irq_set[`AHO_IRQ_FAIL] = rate_bad;
  assign irq_clr = (dout_wr & (dout_sub == 3'h4) & ~processor_io_instruction[`AHO_A4]) ? src[`AHO_IRQ_W-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_lat <= '0;
    end else begin
      irq_lat <= (irq_lat & ~irq_clr) | irq_set;
    end
  end

  assign host_irq_o = (|irq_lat) & ~in_routine_i & ~inhibit & ~muldiv_busy_i;

  // Telemetry word and serializer
  logic [`AHO_TLM_WORD_W-1:0] tlm_word;
  logic tlm_flag;
  logic tlm_last;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tlm_word <= `AHO_TLM_RESET;
      tlm_flag <= 1'b0;
    end else if (tlm_wr) begin
      tlm_word <= {~^src[`AHO_TLM_DATA_W-1:0], src[`AHO_TLM_DATA_W-1:0]};
      tlm_flag <= src[`AHO_TLM_FLAG_BIT];
    end
  end

  aho_tlm_tx u_tx (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .word_i(tlm_word),
    .flag_i(tlm_flag),
    .start_i(req_p),
    .shift_i(shift_p),
    .data_o(tlm_data_o),
    .busy_o(tlm_busy_o),
    .last_o(tlm_last)
  );

  // Delay-line store
  logic [`AHO_DL_W-1:0] dl_rdata;
  aho_regmem #(.AW(4), .DW(`AHO_DL_W)) u_mem (
    .clk_i(clk_i),
    .we_i(dl_wr),
    .waddr_i(dl_slot),
    .wdata_i(src[`AHO_DL_W-1:0]),
    .raddr_i(dl_slot),
    .rdata_o(dl_rdata)
  );

  // Read data selection
  logic [`AHO_WORD_W-1:0] din_word;
  logic [`AHO_WORD_W-1:0] status_word;
  logic [`AHO_DL_W-1:0] dl_word;
  logic [31:0] next_rdata;

  assign status_word = {{(`AHO_WORD_W-3){1'b0}}, inhibit, tlm_busy_o, irq_lat[`AHO_IRQ_FAIL]};
  assign din_word = (din_sub == 5'h01) ? {{(`AHO_WORD_W-`AHO_IRQ_W){1'b0}}, irq_lat} :
                    (din_sub == 5'h02) ? status_word :
                    (din_sub == 5'h04) ? din_s[0 +: `AHO_WORD_W] :
                    (din_sub == 5'h08) ? din_s[`AHO_WORD_W +: `AHO_WORD_W] :
                    (din_sub == 5'h10) ? din_s[2*`AHO_WORD_W +: `AHO_WORD_W] : '0;
  assign dl_word = (dl_slot == `AHO_SLOT_TMR1) ? tmr[0] :
                   (dl_slot == `AHO_SLOT_TMR2) ? tmr[1] : dl_rdata;
  assign next_rdata = ~rd_ok ? 32'h0 :
                      (grp == aho_pkg::AHO_GRP_DIN) ? {6'h00, din_word} :
                      (grp == aho_pkg::AHO_GRP_DLREAD) ? {19'h00000, dl_word} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (fire) begin
      wb_dat_o <= next_rdata;
    end
  end

  // Checks
  sequence s_tlm_load;
    tlm_wr ##1 1'b1;
  endsequence

  chk_tlm_parity: assert property (@(posedge clk_i) disable iff (rst_i) ^tlm_word == 1'b1)
    else $error("telemetry word parity not odd");
  chk_tlm_load: assert property (@(posedge clk_i) disable iff (rst_i)
    tlm_wr |=> tlm_word[14:0] == $past(src[14:0]) && tlm_flag == $past(src[15]))
    else $error("telemetry word or flag not stored");
  chk_irq_block: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_routine_i || inhibit || muldiv_busy_i) |-> !host_irq_o)
    else $error("interrupt raised while gated");
  chk_irq_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(|irq_lat) && !in_routine_i && !inhibit && !muldiv_busy_i |-> host_irq_o)
    else $error("set latch did not interrupt");
  chk_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ($past(irq_lat) & ~$past(irq_clr) & ~irq_lat) == '0)
    else $error("interrupt latch dropped without clear");
  chk_done_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    end_p && !rate_bad && !irq_lat[`AHO_IRQ_FAIL] |=> irq_lat[`AHO_IRQ_DONE])
    else $error("word-done strobe lost");
  chk_rate_fail: assert property (@(posedge clk_i) disable iff (rst_i)
    end_p && tmr2_left > RATE_LIMIT |=> irq_lat[`AHO_IRQ_FAIL] && $stable(irq_lat[`AHO_IRQ_DONE]))
    else $error("fast strobe not flagged");
  chk_dout_set: assert property (@(posedge clk_i) disable iff (rst_i)
    dout_wr && dout_sub == 3'h1 |=> dout0 == ($past(processor_io_instruction[`AHO_A4]) ? ($past(dout0) | $past(src))
      : ($past(dout0) & ~$past(src))))
    else $error("output latch bank not updated");
  chk_inhibit_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    fire |=> inhibit == $past(processor_io_instruction[`AHO_A2]))
    else $error("inhibit does not follow address bit");
  chk_tmr2_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && tmr_run[1] && tmr[1] == {`AHO_DL_W{1'b1}} && !tmr_load[1] |=> irq_lat[`AHO_IRQ_TMR2] && !tmr_run[1])
    else $error("timer two expiry missed");
  chk_tlm_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    s_tlm_load |-> !tlm_last)
    else $error("serializer ended right after a load");

  sequence s_bus_take;
    bus_req && !pend && !wb_ack_o;
  endsequence
  chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i) s_bus_take |=> ##1 wb_ack_o)
    else $error("bus request not answered on the second edge");
  chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held longer than one cycle");
  chk_fail_block: assert property (@(posedge clk_i) disable iff (rst_i)
    end_p && irq_lat[`AHO_IRQ_FAIL] && !irq_lat[`AHO_IRQ_DONE] |=> !irq_lat[`AHO_IRQ_DONE])
    else $error("strobe interrupt not blocked after failure");
  chk_irq_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    |irq_clr |=> (irq_lat & $past(irq_clr) & ~$past(irq_set)) == '0)
    else $error("interrupt latch not cleared");
endmodule
`default_nettype wire

// File: design/aho_defines.svh
// Constants for the adapter host I/O port
`ifndef AHO_DEFINES_SVH
`define AHO_DEFINES_SVH
// Instruction address bit positions within the eight-bit address
`define AHO_A1 0
`define AHO_A2 1
`define AHO_A3 2
`define AHO_A4 3
`define AHO_A5 4
`define AHO_A6 5
`define AHO_A7 6
`define AHO_A8 7
`define AHO_PIO_W 8
// Instruction address taken from Wishbone byte address bits [9:2]
`define AHO_PIO_LSB 2
// Word widths
`define AHO_WORD_W 26
`define AHO_DL_W 13
`define AHO_TLM_DATA_W 15
`define AHO_TLM_WORD_W 16
`define AHO_TLM_FLAG_BIT 15
`define AHO_TLM_BITS 40
`define AHO_TLM_LAST 6'd39
`define AHO_TLM_COPY2 6'd16
`define AHO_TLM_FLAGS 6'd32
`define AHO_TLM_RESET 16'h8000
// Delay-line slot addresses {line2, index}
`define AHO_SLOT_TMR1 4'h0
`define AHO_SLOT_TMR2 4'h1
`define AHO_SLOT_TLM 4'hF
// Interrupt latch bits
`define AHO_IRQ_W 4
`define AHO_IRQ_DONE 0
`define AHO_IRQ_TMR1 1
`define AHO_IRQ_TMR2 2
`define AHO_IRQ_FAIL 3
// Loop time and clock rate
`define AHO_LOOP_NS 164062
`define AHO_CLK_MHZ 200
// Default wired-in constant for the strobe-rate check
`define AHO_RATE_LIMIT 13'h0100
`endif

// File: design/aho_pkg.sv
// Types for the adapter host I/O port
package aho_pkg;
  // Encoded as {space_select_bit, direction_select_bit}
  typedef enum logic [1:0] {
    AHO_GRP_DOUT = 2'b00,
    AHO_GRP_DIN = 2'b01,
    AHO_GRP_DLLOAD = 2'b10,
    AHO_GRP_DLREAD = 2'b11
  } aho_group_t;
  typedef enum logic [1:0] {
    AHO_TX_IDLE = 2'b00,
    AHO_TX_SEND = 2'b01
  } aho_tx_state_t;
endpackage

// File: design/aho_regmem.sv
// Delay-line register store with registered read
`timescale 1ns/1ps
`default_nettype none
module aho_regmem #(
  parameter int AW = 4,
  parameter int DW = 13
) (
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// File: design/aho_tlm_tx.sv
// Telemetry serializer: word twice, then series flag eight times
`timescale 1ns/1ps
`default_nettype none
`include "aho_defines.svh"
module aho_tlm_tx (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Word to send
  input wire logic [`AHO_TLM_WORD_W-1:0] word_i,
  input wire logic flag_i,
  // Equipment strobes, already synchronised, one-cycle pulses
  input wire logic start_i,
  input wire logic shift_i,
  // Serial side
  output logic data_o,
  output logic busy_o,
  output logic last_o
);
  aho_pkg::aho_tx_state_t state;
  logic [5:0] idx;
  logic [5:0] next_idx;

  function automatic logic pick_bit(input logic [`AHO_TLM_WORD_W-1:0] w, input logic f, input logic [5:0] i);
    logic [5:0] j;
    j = 6'h00;
    if (i >= `AHO_TLM_FLAGS) begin
      return f;
    end
    j = (i >= `AHO_TLM_COPY2) ? i - `AHO_TLM_COPY2 : i;
    return w[j[3:0]];
  endfunction

  assign next_idx = idx + 6'h01;
  assign busy_o = (state == aho_pkg::AHO_TX_SEND);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= aho_pkg::AHO_TX_IDLE;
      idx <= 6'h00;
      data_o <= 1'b0;
      last_o <= 1'b0;
    end else begin
      last_o <= 1'b0;
      unique case (state)
        aho_pkg::AHO_TX_IDLE: begin
          if (start_i) begin
            state <= aho_pkg::AHO_TX_SEND;
            idx <= 6'h00;
            data_o <= pick_bit(word_i, flag_i, 6'h00);
          end
        end
        aho_pkg::AHO_TX_SEND: begin
          if (shift_i) begin
            if (idx == `AHO_TLM_LAST) begin
              state <= aho_pkg::AHO_TX_IDLE;
              last_o <= 1'b1;
              data_o <= 1'b0;
            end else begin
              idx <= next_idx;
              data_o <= pick_bit(word_i, flag_i, next_idx);
            end
          end
        end
        default: begin
          state <= aho_pkg::AHO_TX_IDLE;
        end
      endcase
    end
  end

  chk_tx_last: assert property (@(posedge clk_i) disable iff (rst_i) last_o |-> $past(idx) == `AHO_TLM_LAST)
    else $error("serializer ended before the fortieth bit");
  chk_tx_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_o && idx >= `AHO_TLM_FLAGS && $stable(idx) && !$rose(busy_o) |-> data_o == flag_i)
    else $error("series flag bit not sent in last eight positions");
endmodule
`default_nettype wire

// File: dv/aho_tlm_equip.sv
// Telemetry equipment model: requests a word, clocks it out, returns the end strobe
`timescale 1ns/1ps
`default_nettype none
module aho_tlm_equip (
  // Clock
  input wire logic clk_i,
  // Serial side of the port
  input wire logic data_i,
  input wire logic busy_i,
  // Strobes to the port
  output wire logic req_o,
  output wire logic shift_o,
  output wire logic end_o
);
  logic [2:0] pins = 3'h0;
  assign req_o = pins[0];
  assign shift_o = pins[1];
  assign end_o = pins[2];
  // Strobes are held long enough to pass the pin synchronisers
  task automatic pulse(input int k);
    pins[k] <= 1'b1;
    repeat (4) @(posedge clk_i);
    pins[k] <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // Shift strobes run forty times once busy rises or 20 cycles pass
  task automatic get_word(output logic [39:0] bits, output logic ok);
    int n;
    pulse(0);
    n = 0;
    while (busy_i !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    ok = busy_i;
    for (int i = 0; i < 40; i++) begin
      bits[i] = data_i;
      pulse(1);
    end
  endtask
  task automatic send_end();
    pulse(2);
  endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// Testbench for the adapter host I/O port
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [25:0] mem = 26'h0;
  logic in_rt = 1'b0;
  logic md = 1'b0;
  logic [77:0] din = {26'h3000001, 26'h2AAAAAA, 26'h1555555};
  logic [51:0] dout;
  logic irq;
  logic req;
  logic sh;
  logic endp;
  logic tdat;
  logic tbusy;
  int mismatches = 0;
  int num_checks = 0;
  always #2.5 clk_i = ~clk_i;
  aho_port #(.LOOP_CYCLES(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .mem_word_i(mem), .in_routine_i(in_rt), .muldiv_busy_i(md), .host_irq_o(irq), .disc_in_i(din),
    .disc_out_o(dout), .tlm_req_i(req), .tlm_shift_i(sh), .tlm_end_i(endp), .tlm_data_o(tdat),
    .tlm_busy_o(tbusy));
  aho_tlm_equip eq (.clk_i(clk_i), .data_i(tdat), .busy_i(tbusy), .req_o(req), .shift_o(sh),
    .end_o(endp));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic cmp_w(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_b(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {22'h0, a, 2'h0};
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    if (ack !== 1'b1) begin
      mismatches++;
      stop_test();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    cmp_w(r, e);
  endtask
  task automatic t_dout();
    cmp_w(dout, 52'h0);
    mem <= 26'h3000000;
    wr(8'h28, 32'h0F5);
    cmp_w(dout, 52'h0F5);
    wr(8'h20, 32'h005);
    cmp_w(dout, 52'h0F0);
    wr(8'h38, 32'h0);
    cmp_w(dout, 52'h30000F0);
    wr(8'h48, 32'h1);
    wr(8'h68, 32'h3FFFFFF);
    wr(8'h29, 32'h3FFFFFF);
    cmp_w(dout, {26'h1, 26'h30000F0});
    $display("test dout done");
  endtask
  task automatic t_din();
    chk(8'h21, 32'h1555555);
    chk(8'h41, 32'h2AAAAAA);
    chk(8'h81, 32'h3000001);
    chk(8'h31, 32'h0);
    chk(8'h20, 32'h0);
    $display("test din done");
  endtask
  task automatic t_tlm();
    logic [39:0] bits;
    logic ok;
    logic [14:0] d;
    logic [15:0] w;
    logic f;
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 15'h1234 : 15'h1235;
      f = (k == 0);
      w = {~^d, d};
      wr(8'hE4, {16'h0, f, d});
      eq.get_word(bits, ok);
      cmp_b(ok, 1'b1);
      if (ok !== 1'b1) begin
        stop_test();
      end
      cmp_w(bits, {{8{f}}, w, w});
      cmp_b(tbusy, 1'b0);
    end
    chk(8'hE5, 32'h1235);
    chk(8'h09, 32'h0);
    eq.send_end();
    chk(8'h09, 32'h1);
    cmp_b(irq, 1'b1);
    wr(8'h8C, 32'h1000);
    $display("test tlm done");
  endtask
  task automatic t_gate();
    in_rt <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp_b(irq, 1'b0);
    in_rt <= 1'b0;
    md <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp_b(irq, 1'b0);
    md <= 1'b0;
    wr(8'h02, 32'h0);
    chk(8'h13, 32'h4);
    cmp_b(irq, 1'b0);
    chk(8'h09, 32'h1);
    cmp_b(irq, 1'b1);
    wr(8'h80, 32'h1);
    chk(8'h09, 32'h0);
    cmp_b(irq, 1'b0);
    $display("test gate done");
  endtask
  task automatic t_timer();
    wr(8'h0C, 32'h1FFD);
    wr(8'h8C, 32'h1FFE);
    chk(8'h09, 32'h0);
    repeat (40) @(posedge clk_i);
    chk(8'h09, 32'h6);
    wr(8'h80, 32'h6);
    chk(8'h09, 32'h0);
    $display("test timer done");
  endtask
  task automatic t_fail();
    wr(8'h8C, 32'h1E00);
    eq.send_end();
    chk(8'h09, 32'h8);
    chk(8'h11, 32'h1);
    wr(8'h8C, 32'h0);
    eq.send_end();
    chk(8'h09, 32'h8);
    $display("test fail done");
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_dout();
    t_din();
    t_tlm();
    t_gate();
    t_timer();
    t_fail();
    stop_test();
  end
endmodule
`default_nettype wire
